// File: core/a429_rx_consts.vh
// constants for the dual arinc 429 receiver and its option latch
// assumes inclusion by bare name from design files under core/
`ifndef A429_RX_CONSTS_VH
`define A429_RX_CONSTS_VH

// option latch: ten bits captured from data bus lines 14..5
`define OPT_WIDTH 10
`define OPT_BUS_LSB 5
`define OPT_RESET 10'h001
`define OPT_LOOPBACK_N 0
`define OPT_RX1_FILT 1
`define OPT_RX1_M9 2
`define OPT_RX1_M10 3
`define OPT_RX2_FILT 4
`define OPT_RX2_M9 5
`define OPT_RX2_M10 6
`define OPT_TX_PAR_EVEN 7
`define OPT_TX_RATE_SLOW 8
`define OPT_RX_RATE_SLOW 9

// master clock divide ratios, stored as terminal counts (ratio - 1)
`define DIV_FAST_LAST 7'h09
`define DIV_SLOW_LAST 7'h4f

// receiver timing in samples, and the last bit index of a word
`define BIT_SPACE_MIN 4'h8
`define BIT_SPACE_MAX 4'hc
`define GAP_NULLS 2'h3
`define WORD_LAST_BIT 5'h1f

// receive state machine codes
`define ST_GAP 2'h0
`define ST_IDLE 2'h1
`define ST_BITS 2'h2
`define ST_DELIVER 2'h3

`endif

// File: core/line_sampler.v
// ten-sample shift registers and level validity for one receiver input
// assumes comparator levels synchronous to the clock, sample_en a pulse
`timescale 1ns/1ps
module line_sampler #(
  parameter DEPTH = 10
) (
  input wire sys_clk_in,
  input wire rst_n_in,
  input wire sample_en_in,
  input wire line_one_in,
  input wire line_zero_in,
  output wire one_bit_out,
  output wire zero_bit_out,
  output wire gap_null_out,
  output wire bad_level_out
);
  reg [DEPTH-1:0] one_sr_q;
  reg [DEPTH-1:0] zero_sr_q;
  reg [DEPTH-1:0] null_sr_q;
  reg bad_q;

  // newest sample enters at bit 0, so the lower bits are the latest
  always @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      one_sr_q <= {DEPTH{1'b0}};
      zero_sr_q <= {DEPTH{1'b0}};
      null_sr_q <= {DEPTH{1'b0}};
      bad_q <= 1'b0;
    end else if (sample_en_in) begin
      one_sr_q <= {one_sr_q[DEPTH-2:0], line_one_in & ~line_zero_in};
      zero_sr_q <= {zero_sr_q[DEPTH-2:0], line_zero_in & ~line_one_in};
      null_sr_q <= {null_sr_q[DEPTH-2:0], ~line_one_in & ~line_zero_in};
      // both comparators on means the level is in no accepted range
      bad_q <= line_one_in & line_zero_in;
    end
  end

  // three like samples at the top, then three nulls at the bottom
  assign one_bit_out = (&one_sr_q[DEPTH-1:DEPTH-3]) &
                       (&null_sr_q[2:0]);
  assign zero_bit_out = (&zero_sr_q[DEPTH-1:DEPTH-3]) &
                        (&null_sr_q[2:0]);
  assign gap_null_out = (&null_sr_q[DEPTH-1:DEPTH-3]) &
                        (&null_sr_q[2:0]);
  assign bad_level_out = bad_q;
endmodule

// File: core/pair_buffer.v
// two-entry word buffer with valid and ready on both sides
// assumes one clock; the drain side may stall at will
`timescale 1ns/1ps
module pair_buffer #(
  parameter WIDTH = 32
) (
  input wire sys_clk_in,
  input wire rst_n_in,
  input wire in_valid_in,
  output wire in_ready_out,
  input wire [WIDTH-1:0] in_data_in,
  output wire out_valid_out,
  input wire out_ready_in,
  output wire [WIDTH-1:0] out_data_out
);
  reg [WIDTH-1:0] mem_q [0:1];
  reg wr_ptr_q;
  reg rd_ptr_q;
  reg [1:0] count_q;
  wire push;
  wire pop;

  assign in_ready_out = (count_q != 2'h2);
  assign out_valid_out = (count_q != 2'h0);
  assign out_data_out = mem_q[rd_ptr_q];
  assign push = in_valid_in & in_ready_out;
  assign pop = out_valid_out & out_ready_in;

  always @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
      count_q <= 2'h0;
      mem_q[0] <= {WIDTH{1'b0}};
      mem_q[1] <= {WIDTH{1'b0}};
    end else begin
      if (push) begin
        mem_q[wr_ptr_q] <= in_data_in;
        wr_ptr_q <= ~wr_ptr_q;
      end
      if (pop) begin
        rd_ptr_q <= ~rd_ptr_q;
      end
      if (push & ~pop) begin
        count_q <= count_q + 2'h1;
      end else if (pop & ~push) begin
        count_q <= count_q - 2'h1;
      end
    end
  end
endmodule

// File: core/arinc429_dual_receiver_ctrl.v
// option latch, rate dividers and two arinc 429 receive channels
// assumes all pins synchronous to sys_clk_in; the bus wire is resolved
// outside from data_bus_out and data_bus_oe_out
//
// Summary of operation
// - ten option flip-flops capture bus lines on each option strobe pulse
// - loopback bit low feeds transmitter digital outputs into receivers
// - receiver 1 filter on: bits 9 and 10 must equal next two options
// - receiver 2 filter on: bits 9 and 10 must equal next two options
// - transmit parity select: 0 gives odd parity, 1 gives even
// - transmit rate select divides master clock by 10 or by 80
// - receive rate select divides master clock by 10 or by 80
// - arinc bit 1 is the first bit on the line
// - fixed mapping of arinc bits onto bus lines for bytes 1 and 2
// - any line level outside accepted ranges rejects the word
// - ten-sample shift registers, three like samples make a valid level
// - data one or zero must be followed by null within a bit time
// - gap null needs three nulls in both upper and lower samples
// - each bit starts 8 to 12 samples after the previous one
// - gap timer counts nulls each sample; three nulls re-arm reception
// - bit 32 shows 0 when ones over all 32 bits are odd
// - end-of-word event once 32 valid bits are assembled
// - on end of word passing the filter, data-ready goes low
// - data-ready stays low until both bytes are read
// - a new word before both bytes are read overwrites the held word
// - lines are sampled at ten times the nominal data rate
// - receiver 2 drives the bus only while receiver 1 enable is high
// - master reset is active low
`timescale 1ns/1ps
`include "a429_rx_consts.vh"
module arinc429_dual_receiver_ctrl #(
  parameter WORD_WIDTH = 32,
  parameter BUS_WIDTH = 16,
  parameter SAMPLE_DEPTH = 10
) (
  input wire sys_clk_in,
  input wire rst_n_in,
  input wire option_strobe_in,
  input wire byte_select_in,
  input wire rx1_read_enable_n_in,
  input wire rx2_read_enable_n_in,
  input wire [BUS_WIDTH-1:0] data_bus_in,
  output wire [BUS_WIDTH-1:0] data_bus_out,
  output wire data_bus_oe_out,
  input wire rx1_line_one_in,
  input wire rx1_line_zero_in,
  input wire rx2_line_one_in,
  input wire rx2_line_zero_in,
  input wire tx_serial_one_in,
  input wire tx_serial_zero_in,
  input wire [WORD_WIDTH-2:0] tx_word_in,
  output wire tx_parity_bit_out,
  output wire tx_bit_clk_en_out,
  output wire loopback_select_n_out,
  output wire tx_parity_even_select_out,
  output wire tx_rate_slow_select_out,
  output wire rx1_word_waiting_n_out,
  output wire rx2_word_waiting_n_out
);

  // ----------------------------------------------------------------
  // helper functions
  // ----------------------------------------------------------------
  function [6:0] div_last;
    input slow;
    begin
      div_last = slow ? `DIV_SLOW_LAST : `DIV_FAST_LAST;
    end
  endfunction

  // first byte: bits 13..9, 31, 30, 32, then bits 1..8
  function [15:0] byte_one;
    input [31:0] w;
    begin
      byte_one = {w[12:8], w[30], w[29], w[31],
                  w[0], w[1], w[2], w[3], w[4], w[5], w[6], w[7]};
    end
  endfunction

  // second byte: bits 29..14
  function [15:0] byte_two;
    input [31:0] w;
    begin
      byte_two = w[28:13];
    end
  endfunction

  function [15:0] pick_byte;
    input [31:0] w;
    input sel;
    begin
      pick_byte = sel ? byte_two(w) : byte_one(w);
    end
  endfunction

  // ----------------------------------------------------------------
  // option latch
  // ----------------------------------------------------------------
  reg [`OPT_WIDTH-1:0] option_latch_q;
  reg strobe_prev_q;
  wire strobe_rise;

  assign strobe_rise = option_strobe_in & ~strobe_prev_q;

  // reset leaves loopback off and both filters open
  always @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      option_latch_q <= `OPT_RESET;
      strobe_prev_q <= 1'b0;
    end else begin
      strobe_prev_q <= option_strobe_in;
      if (strobe_rise) begin
        option_latch_q <=
          data_bus_in[`OPT_BUS_LSB +: `OPT_WIDTH];
      end
    end
  end

  wire loopback_select_n;
  wire tx_parity_even_select;
  wire tx_rate_slow_select;
  wire rx_rate_slow_select;
  wire [1:0] filter_enable;
  wire [1:0] match_bit9;
  wire [1:0] match_bit10;

  assign loopback_select_n = option_latch_q[`OPT_LOOPBACK_N];
  assign tx_parity_even_select = option_latch_q[`OPT_TX_PAR_EVEN];
  assign tx_rate_slow_select = option_latch_q[`OPT_TX_RATE_SLOW];
  assign rx_rate_slow_select = option_latch_q[`OPT_RX_RATE_SLOW];
  assign filter_enable = {option_latch_q[`OPT_RX2_FILT],
                          option_latch_q[`OPT_RX1_FILT]};
  assign match_bit9 = {option_latch_q[`OPT_RX2_M9],
                       option_latch_q[`OPT_RX1_M9]};
  assign match_bit10 = {option_latch_q[`OPT_RX2_M10],
                        option_latch_q[`OPT_RX1_M10]};

  assign loopback_select_n_out = loopback_select_n;
  assign tx_parity_even_select_out = tx_parity_even_select;
  assign tx_rate_slow_select_out = tx_rate_slow_select;

  // ----------------------------------------------------------------
  // rate dividers
  // ----------------------------------------------------------------
  reg [6:0] rx_div_q;
  reg [6:0] tx_div_q;
  reg sample_q;
  reg tx_bit_clk_q;
  wire rx_tick;
  wire tx_tick;

  // a rate change mid-count is safe: the compare is >= not ==
  assign rx_tick = (rx_div_q >= div_last(rx_rate_slow_select));
  assign tx_tick = (tx_div_q >= div_last(tx_rate_slow_select));

  always @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rx_div_q <= 7'h00;
      tx_div_q <= 7'h00;
      sample_q <= 1'b0;
      tx_bit_clk_q <= 1'b0;
    end else begin
      rx_div_q <= rx_tick ? 7'h00 : rx_div_q + 7'h01;
      tx_div_q <= tx_tick ? 7'h00 : tx_div_q + 7'h01;
      // delayed copy: samplers update on the tick, logic reads after
      sample_q <= rx_tick;
      tx_bit_clk_q <= tx_tick;
    end
  end

  assign tx_bit_clk_en_out = tx_bit_clk_q;

  // ----------------------------------------------------------------
  // transmit parity bit
  // ----------------------------------------------------------------
  reg tx_parity_q;

  always @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tx_parity_q <= 1'b0;
    end else begin
      tx_parity_q <= (^tx_word_in) ^ ~tx_parity_even_select;
    end
  end

  assign tx_parity_bit_out = tx_parity_q;

  // ----------------------------------------------------------------
  // line selection and host read decode
  // ----------------------------------------------------------------
  wire [1:0] line_one;
  wire [1:0] line_zero;
  wire [1:0] read_active;

  // in loopback receiver 2 sees the complement of the transmitter
  assign line_one[0] = loopback_select_n ? rx1_line_one_in
                                         : tx_serial_one_in;
  assign line_zero[0] = loopback_select_n ? rx1_line_zero_in
                                          : tx_serial_zero_in;
  assign line_one[1] = loopback_select_n ? rx2_line_one_in
                                         : tx_serial_zero_in;
  assign line_zero[1] = loopback_select_n ? rx2_line_zero_in
                                          : tx_serial_one_in;

  assign read_active[0] = ~rx1_read_enable_n_in;
  assign read_active[1] = ~rx2_read_enable_n_in &
                          rx1_read_enable_n_in;

  wire [2*WORD_WIDTH-1:0] hold_word;
  wire [1:0] word_waiting;

  // ----------------------------------------------------------------
  // receive channels
  // ----------------------------------------------------------------
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch = ch + 1) begin : g_ch
      wire s_one;
      wire s_zero;
      wire s_gnull;
      wire s_bad;
      wire s_level;
      wire bit_edge;
      wire word_complete_event;
      wire accept;
      wire push_valid;
      wire push_ready;
      wire drain_valid;
      wire drain_ready;
      wire [WORD_WIDTH-1:0] drain_word;
      wire load;
      wire got1_d;
      wire got2_d;
      reg [1:0] state_q;
      reg [4:0] bit_idx_q;
      reg [3:0] space_q;
      reg [1:0] gap_q;
      reg [WORD_WIDTH-1:0] word_q;
      reg parity_q;
      reg prev_level_q;
      reg [WORD_WIDTH-1:0] hold_q;
      reg waiting_q;
      reg got1_q;
      reg got2_q;

      line_sampler #(
        .DEPTH(SAMPLE_DEPTH)
      ) u_sampler (
        .sys_clk_in(sys_clk_in),
        .rst_n_in(rst_n_in),
        .sample_en_in(rx_tick),
        .line_one_in(line_one[ch]),
        .line_zero_in(line_zero[ch]),
        .one_bit_out(s_one),
        .zero_bit_out(s_zero),
        .gap_null_out(s_gnull),
        .bad_level_out(s_bad)
      );

      // a bit is taken once, when its pattern first appears
      assign s_level = s_one | s_zero;
      assign bit_edge = s_level & ~prev_level_q;

      assign word_complete_event = (state_q == `ST_DELIVER);
      assign accept = ~filter_enable[ch] |
                      ((word_q[8] == match_bit9[ch]) &
                       (word_q[9] == match_bit10[ch]));
      assign push_valid = word_complete_event & accept;

      always @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          state_q <= `ST_GAP;
          bit_idx_q <= 5'h00;
          space_q <= 4'h0;
          gap_q <= 2'h0;
          word_q <= {WORD_WIDTH{1'b0}};
          parity_q <= 1'b0;
          prev_level_q <= 1'b0;
        end else if (state_q == `ST_DELIVER) begin
          // a filtered word, or one taken by the buffer, ends here
          if (~accept | push_ready) begin
            state_q <= `ST_GAP;
          end
        end else if (sample_q) begin
          prev_level_q <= s_level;
          if (space_q != 4'hf) begin
            space_q <= space_q + 4'h1;
          end
          case (state_q)
            `ST_GAP: begin
              if (s_bad | ~s_gnull) begin
                gap_q <= 2'h0;
              end else if (gap_q + 2'h1 == `GAP_NULLS) begin
                gap_q <= 2'h0;
                state_q <= `ST_IDLE;
              end else begin
                gap_q <= gap_q + 2'h1;
              end
            end
            `ST_IDLE: begin
              if (s_bad) begin
                state_q <= `ST_GAP;
              end else if (bit_edge) begin
                word_q[0] <= s_one;
                parity_q <= s_one;
                bit_idx_q <= 5'h01;
                space_q <= 4'h0;
                state_q <= `ST_BITS;
              end
            end
            `ST_BITS: begin
              if (s_bad) begin
                state_q <= `ST_GAP;
              end else if (~bit_edge & (space_q >= `BIT_SPACE_MAX)) begin
                state_q <= `ST_GAP;
              end else if (bit_edge) begin
                space_q <= 4'h0;
                if ((space_q + 4'h1 < `BIT_SPACE_MIN) |
                    (space_q + 4'h1 > `BIT_SPACE_MAX)) begin
                  state_q <= `ST_GAP;
                end else if (bit_idx_q == `WORD_LAST_BIT) begin
                  word_q[WORD_WIDTH-1] <= ~(parity_q ^ s_one);
                  state_q <= `ST_DELIVER;
                end else begin
                  word_q[bit_idx_q] <= s_one;
                  parity_q <= parity_q ^ s_one;
                  bit_idx_q <= bit_idx_q + 5'h01;
                end
              end
            end
            default: begin
              state_q <= `ST_GAP;
            end
          endcase
        end
      end

      // holding the drain during a read keeps the bytes of one read
      // from two words; a long read stalls the channel instead
      assign drain_ready = ~read_active[ch];

      pair_buffer #(
        .WIDTH(WORD_WIDTH)
      ) u_buffer (
        .sys_clk_in(sys_clk_in),
        .rst_n_in(rst_n_in),
        .in_valid_in(push_valid),
        .in_ready_out(push_ready),
        .in_data_in(word_q),
        .out_valid_out(drain_valid),
        .out_ready_in(drain_ready),
        .out_data_out(drain_word)
      );

      assign load = drain_valid & drain_ready;
      assign got1_d = got1_q | (read_active[ch] & ~byte_select_in);
      assign got2_d = got2_q | (read_active[ch] & byte_select_in);

      // a new word beats the clear from a finished read
      always @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          hold_q <= {WORD_WIDTH{1'b0}};
          waiting_q <= 1'b0;
          got1_q <= 1'b0;
          got2_q <= 1'b0;
        end else if (load) begin
          hold_q <= drain_word;
          waiting_q <= 1'b1;
          got1_q <= 1'b0;
          got2_q <= 1'b0;
        end else if (got1_d & got2_d) begin
          waiting_q <= 1'b0;
          got1_q <= 1'b0;
          got2_q <= 1'b0;
        end else begin
          got1_q <= got1_d & waiting_q;
          got2_q <= got2_d & waiting_q;
        end
      end

      assign hold_word[ch*WORD_WIDTH +: WORD_WIDTH] = hold_q;
      assign word_waiting[ch] = waiting_q;
    end
  endgenerate

  // ----------------------------------------------------------------
  // parallel bus output
  // ----------------------------------------------------------------
  reg [BUS_WIDTH-1:0] bus_data_q;
  reg bus_oe_q;

  // data and enable are both registered so they change together
  always @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      bus_data_q <= 16'h0000;
      bus_oe_q <= 1'b0;
    end else begin
      bus_oe_q <= read_active[0] | read_active[1];
      if (read_active[0]) begin
        bus_data_q <= pick_byte(hold_word[WORD_WIDTH-1:0],
                                byte_select_in);
      end else begin
        bus_data_q <= pick_byte(hold_word[2*WORD_WIDTH-1:WORD_WIDTH],
                                byte_select_in);
      end
    end
  end

  assign data_bus_out = bus_data_q;
  assign data_bus_oe_out = bus_oe_q;
  assign rx1_word_waiting_n_out = ~word_waiting[0];
  assign rx2_word_waiting_n_out = ~word_waiting[1];

endmodule

// File: tb/dual_rx_asserts.sv
// port assertions for the dual receiver and its option latch
// assumes one clock domain and the active-low asynchronous reset
`timescale 1ns/1ps
module dual_rx_asserts #(
  parameter WORD_WIDTH = 32,
  parameter BUS_WIDTH = 16
) (
  input wire sys_clk_in,
  input wire rst_n_in,
  input wire option_strobe_in,
  input wire rx1_read_enable_n_in,
  input wire rx2_read_enable_n_in,
  input wire [BUS_WIDTH-1:0] data_bus_in,
  input wire data_bus_oe_out,
  input wire [WORD_WIDTH-2:0] tx_word_in,
  input wire tx_parity_bit_out,
  input wire tx_bit_clk_en_out,
  input wire loopback_select_n_out,
  input wire tx_parity_even_select_out,
  input wire tx_rate_slow_select_out,
  input wire rx1_word_waiting_n_out,
  input wire rx2_word_waiting_n_out
);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  chk_opt_capture: assert property ($rose(option_strobe_in) |=>
    loopback_select_n_out == $past(data_bus_in[5]) &&
    tx_parity_even_select_out == $past(data_bus_in[12]) &&
    tx_rate_slow_select_out == $past(data_bus_in[13]))
    else $error("option latch missed the bus value");
  chk_opt_hold: assert property (!$rose(option_strobe_in) |=>
    $stable(loopback_select_n_out) && $stable(tx_rate_slow_select_out))
    else $error("option bit changed without a strobe");
  // parity is odd over the word plus the bit unless even is selected
  chk_tx_parity: assert property ($past(rst_n_in) |->
    tx_parity_bit_out ==
    ^{$past(tx_word_in), ~$past(tx_parity_even_select_out)})
    else $error("transmit parity bit wrong");
  chk_tx_clk_gap: assert property (tx_bit_clk_en_out |=>
    !tx_bit_clk_en_out [*8])
    else $error("transmit clock pulses too close");
  chk_tx_clk_due: assert property (tx_bit_clk_en_out |->
    ##[1:80] tx_bit_clk_en_out)
    else $error("transmit clock pulse missing");
  chk_rd_drive: assert property (!rx1_read_enable_n_in |=>
    data_bus_oe_out)
    else $error("bus not driven during read");
  chk_oe_cause: assert property (data_bus_oe_out |->
    $past(!rx1_read_enable_n_in || !rx2_read_enable_n_in))
    else $error("bus driven with no enable");
  chk_flag1_clear: assert property ($rose(rx1_word_waiting_n_out) |->
    $past(!rx1_read_enable_n_in))
    else $error("receiver 1 flag cleared without a read");
  chk_flag2_clear: assert property ($rose(rx2_word_waiting_n_out)
    |-> $past(!rx2_read_enable_n_in && rx1_read_enable_n_in))
    else $error("receiver 2 flag cleared without a read");
  chk_reset_state: assert property (disable iff (1'b0) !rst_n_in |->
    rx1_word_waiting_n_out && rx2_word_waiting_n_out && !data_bus_oe_out)
    else $error("reset left a flag or the bus active");
  cover property ($fell(rx1_word_waiting_n_out));
  cover property ($fell(rx2_word_waiting_n_out));
  cover property ($rose(option_strobe_in));
endmodule

bind arinc429_dual_receiver_ctrl dual_rx_asserts #(
  .WORD_WIDTH(WORD_WIDTH),
  .BUS_WIDTH(BUS_WIDTH)
) i_chk (
  .sys_clk_in, .rst_n_in, .option_strobe_in, .rx1_read_enable_n_in,
  .rx2_read_enable_n_in, .data_bus_in, .data_bus_oe_out, .tx_word_in,
  .tx_parity_bit_out, .tx_bit_clk_en_out, .loopback_select_n_out,
  .tx_parity_even_select_out, .tx_rate_slow_select_out,
  .rx1_word_waiting_n_out, .rx2_word_waiting_n_out
);

// File: tb/host_bus_model.sv
// host processor on the parallel bus: option writes and word reads
// assumes the bench calls its tasks; the bus wire is resolved here
`timescale 1ns/1ps
module host_bus_model (
  input wire sys_clk_in,
  input wire [15:0] data_bus_out,
  input wire data_bus_oe_out,
  output logic strobe_out = 1'b0,
  output logic sel_out = 1'b0,
  output logic en1_n_out = 1'b1,
  output logic en2_n_out = 1'b1,
  output wire [15:0] bus_out
);
  // ----------------------------------------------------------------
  // bus tasks
  // ----------------------------------------------------------------
  logic [15:0] drv_q = 16'h0000;
  assign bus_out = data_bus_oe_out ? data_bus_out : drv_q;
  // a released bus shows the inverse so stale option data cannot pass
  task wr_opt(input logic [15:0] v);
    @(posedge sys_clk_in);
    drv_q <= v;
    strobe_out <= 1'b1;
    @(posedge sys_clk_in);
    drv_q <= ~v;
    strobe_out <= 1'b0;
    @(posedge sys_clk_in);
  endtask
  // mode 0 reads receiver 1, 1 receiver 2, 2 asserts both enables
  task rd(input int mode, output logic [15:0] b1, output logic [15:0] b2);
    @(posedge sys_clk_in);
    en1_n_out <= (mode == 1);
    en2_n_out <= (mode == 0);
    sel_out <= 1'b0;
    repeat (2) @(posedge sys_clk_in);
    b1 = bus_out;
    sel_out <= 1'b1;
    repeat (2) @(posedge sys_clk_in);
    b2 = bus_out;
    en1_n_out <= 1'b1;
    en2_n_out <= 1'b1;
  endtask
endmodule

// File: tb/arinc429_dual_receiver_ctrl_bench.sv
// self-checking bench: serial words in, host reads and option writes
// assumes the host model resolves the bus and drives the host pins
`timescale 1ns/1ps
module arinc429_dual_receiver_ctrl_bench;
  logic sys_clk_in = 1'b0;
  logic rst_n_in = 1'b1;
  logic [2:0] one_q = 3'b000;
  logic [2:0] zero_q = 3'b000;
  logic [30:0] tx_word_q = 31'h0000_0000;
  wire strobe, sel, en1_n, en2_n, oe, tx_par, tx_clk_en;
  wire lb_n, par_even, rate_slow, flag1_n, flag2_n;
  wire [15:0] bus_in;
  wire [15:0] bus_out;
  int fails = 0;
  int samples_checked = 0;
  localparam logic [31:0] w_a = 32'h1234_5678;
  localparam logic [31:0] w_b = 32'h8765_4321;
  localparam logic [31:0] w_c = 32'h0f0f_0155;
  localparam logic [31:0] w_d = 32'ha5a5_5d33;

  arinc429_dual_receiver_ctrl i_dut (
    .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
    .option_strobe_in(strobe), .byte_select_in(sel),
    .rx1_read_enable_n_in(en1_n), .rx2_read_enable_n_in(en2_n),
    .data_bus_in(bus_in), .data_bus_out(bus_out), .data_bus_oe_out(oe),
    .rx1_line_one_in(one_q[0]), .rx1_line_zero_in(zero_q[0]),
    .rx2_line_one_in(one_q[1]), .rx2_line_zero_in(zero_q[1]),
    .tx_serial_one_in(one_q[2]), .tx_serial_zero_in(zero_q[2]),
    .tx_word_in(tx_word_q), .tx_parity_bit_out(tx_par),
    .tx_bit_clk_en_out(tx_clk_en), .loopback_select_n_out(lb_n),
    .tx_parity_even_select_out(par_even),
    .tx_rate_slow_select_out(rate_slow),
    .rx1_word_waiting_n_out(flag1_n), .rx2_word_waiting_n_out(flag2_n)
  );
  host_bus_model i_host (
    .sys_clk_in(sys_clk_in), .data_bus_out(bus_out),
    .data_bus_oe_out(oe), .strobe_out(strobe), .sel_out(sel),
    .en1_n_out(en1_n), .en2_n_out(en2_n), .bus_out(bus_in)
  );

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  initial forever #5 sys_clk_in = ~sys_clk_in;
  always @(posedge sys_clk_in) tx_word_q <= tx_word_q + 31'h0000_0001;

  function automatic logic [15:0] byte1(input logic [31:0] w);
    logic [7:0] r;
    for (int i = 0; i < 8; i++) r[7-i] = w[i];
    byte1 = {w[12:8], w[30], w[29], ~^w, r};
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // ten-sample bits: five ticks of level then five of null
  task automatic send(input int ch, input logic [31:0] w, input bit bad);
    for (int i = 0; i < 32; i++) begin
      @(posedge sys_clk_in);
      one_q[ch] <= w[i] | (bad && i == 5);
      zero_q[ch] <= !w[i] | (bad && i == 5);
      repeat (49) @(posedge sys_clk_in);
      one_q[ch] <= 1'b0;
      zero_q[ch] <= 1'b0;
      repeat (50) @(posedge sys_clk_in);
    end
    // the gap needs the last level shifted out and three null ticks
    repeat (150) @(posedge sys_clk_in);
  endtask
  task automatic rd_chk(input int mode, input logic [31:0] w);
    logic [15:0] b1, b2;
    i_host.rd(mode, b1, b2);
    chk(b1, byte1(w));
    chk(b2, w[28:13]);
    repeat (2) @(posedge sys_clk_in);
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    logic [15:0] b1, b2;
    // a falling edge at time zero resets before the first clock edge
    rst_n_in <= 1'b0;
    repeat (12) @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
    @(posedge sys_clk_in);
    chk({10'h000, lb_n, par_even, rate_slow, flag1_n, flag2_n, oe},
      16'h0026);
    // the sample registers reset to zero, so ten nulls fill them first
    repeat (200) @(posedge sys_clk_in);
    send(0, w_a, 1'b0);
    chk({15'h0000, flag1_n}, 16'h0000);
    rd_chk(0, w_a);
    chk({15'h0000, flag1_n}, 16'h0001);
    send(1, w_b, 1'b0);
    i_host.rd(2, b1, b2);
    chk(b1, byte1(w_a));
    chk(b2, w_a[28:13]);
    repeat (2) @(posedge sys_clk_in);
    chk({15'h0000, flag2_n}, 16'h0000);
    rd_chk(1, w_b);
    chk({15'h0000, flag2_n}, 16'h0001);
    i_host.wr_opt(16'h00e0);
    send(0, w_a, 1'b0);
    chk({15'h0000, flag1_n}, 16'h0001);
    send(0, w_c, 1'b0);
    chk({15'h0000, flag1_n}, 16'h0000);
    send(0, w_d, 1'b0);
    rd_chk(0, w_d);
    i_host.wr_opt(16'h30e0);
    chk({13'h0000, lb_n, par_even, rate_slow}, 16'h0007);
    send(0, w_d, 1'b1);
    chk({15'h0000, flag1_n}, 16'h0001);
    i_host.wr_opt(16'h0000);
    send(2, w_a, 1'b0);
    chk({15'h0000, flag1_n}, 16'h0000);
    chk({15'h0000, flag2_n}, 16'h0000);
    rd_chk(0, w_a);
    rst_n_in <= 1'b0;
    repeat (3) @(posedge sys_clk_in);
    chk({14'h0000, flag1_n, flag2_n}, 16'h0003);
    rst_n_in <= 1'b1;
    print_verdict;
  end
  initial begin
    repeat (60000) @(posedge sys_clk_in);
    fails++;
    print_verdict;
  end
endmodule
